// ### scfe_front_end.sv
// serial command front end: echo, line editing, break, error recovery, replies
// assumes a uart outside delivering 8-bit bytes, and a parser taking bytes and replies
`timescale 1ns/10ps
module scfe_front_end (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire scfe_pkg::scfe_rx_s rx,
  input  wire logic              echo_on,
  input  wire logic              verbose_set,
  input  wire logic              verbose_val,
  input  wire logic              long_response_form,
  input  wire logic              soft_flow_on,
  input  wire logic [1:0]        term_sel,
  input  wire logic              bblock_start,
  input  wire logic [15:0]       bblock_len,
  input  wire logic              powerup_done,
  input  wire logic              selftest_fail,
  input  wire logic              cmd_done,
  input  wire logic              cmd_err,
  input  wire logic [9:0]        cmd_err_code,
  input  wire logic              cmd_is_query,
  input  wire logic              tx_ready,
  input  wire logic              reply_busy,
  input  wire logic              cmd_ready,
  output logic                   cmd_valid,
  output logic [7:0]             cmd_data,
  output logic                   cmd_restart,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  output logic                   reply_ok,
  output logic                   reply_event,
  output logic [9:0]             reply_code,
  output logic                   reply_text,
  output logic                   reply_answer,
  output scfe_pkg::scfe_evt_s    evt,
  output logic                   display_err,
  output logic                   verbose,
  output logic                   in_bblock
);
  import scfe_pkg::*;

  function automatic logic is_ctl(input logic [7:0] c);
    is_ctl = (c < CH_SPACE) || (c == CH_DEL);
  endfunction

  function automatic logic is_term(input logic [7:0] c);
    is_term = (c == CH_CR) || (c == CH_LF);
  endfunction

  scfe_state_e        st_q, st_d;
  logic [7:0]         line_q [LINE_MAX];
  logic [LINE_AW-1:0] len_q;
  logic [LINE_AW-1:0] rp_q;
  logic               esc_q;
  logic               drop_q;
  logic               xoff_q;
  logic               flow_pend_q;
  logic [7:0]         echo_q;
  logic [1:0]         ack_q;
  logic [15:0]        blk_q;
  logic               verbose_q;
  logic               cmd_err_seen_q;
  logic               pwr_sent_q;

  wire        rx_ok      = rx.valid && !rx.brk;
  wire        rx_error   = rx.valid && (rx.par_err || rx.frm_err || rx.ovr_err);
  wire [9:0]  rx_err_cd  = rx.par_err ? EV_PARITY : (rx.frm_err ? EV_FRAMING : EV_OVERRUN);
  wire        in_blk     = (blk_q != 16'h0000);
  wire        esc_char   = (rx.data == CH_BS) || (rx.data == CH_LF) || (rx.data == CH_CR) ||
                           (rx.data == CH_DC2) || (rx.data == CH_NAK) || (rx.data == CH_DEL);
  wire        flow_char  = (rx.data == CH_DC1) || (rx.data == CH_DC3);
  wire        edit_char  = rx_ok && echo_on && !esc_q && !in_blk && esc_char;
  wire        do_erase   = edit_char && ((rx.data == CH_BS) || (rx.data == CH_DEL));
  wire        do_kill    = edit_char && (rx.data == CH_NAK);
  wire        do_replay  = edit_char && (rx.data == CH_DC2);
  wire        line_end   = edit_char && is_term(rx.data);
  wire        take_esc   = rx_ok && echo_on && !esc_q && !in_blk && (rx.data == CH_BSL);
  wire        store_chr  = rx_ok && echo_on && !in_blk && !take_esc && !edit_char &&
                           !(flow_char && soft_flow_on && !esc_q);
  wire        line_full  = store_chr && (len_q == LINE_AW'(LINE_MAX));
  wire        idle_st    = (st_q == ST_IDLE);
  wire        pass_end   = drop_q && ((rx.data == CH_SEMI) || is_term(rx.data));
  wire        xoff_need  = soft_flow_on && !xoff_q && (len_q >= LINE_AW'(XOFF_LEVEL));
  wire        xon_need   = soft_flow_on && xoff_q && (len_q <= LINE_AW'(XON_LEVEL));

  // caret echo gated: escaped or plain control depending on class
  wire        echo_ctl   = is_ctl(rx.data) && (esc_q || (!esc_char && !flow_char) ||
                           (flow_char && !soft_flow_on));

  // state machine for the serial output side
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (rx.valid && rx.brk)
          st_d = echo_on ? ST_PRMT : ST_ACK;
        else if (rx_error && echo_on)
          st_d = ST_PRMT;
        else if (do_replay)
          st_d = ST_RPLAY;
        else if (do_kill || line_full)
          st_d = ST_TERM;
        else if (rx_ok && echo_on && !take_esc && !edit_char && is_ctl(rx.data) && echo_ctl)
          st_d = ST_CARET;
        else if (rx_ok && echo_on && !edit_char && !is_ctl(rx.data))
          st_d = ST_ECHO;
        else if (line_end)
          st_d = ST_FLUSH;
      end
      ST_PRMT:  if (tx_ready) st_d = ST_IDLE;
      ST_ECHO:  if (tx_ready) st_d = ST_IDLE;
      ST_CARET: if (tx_ready) st_d = ST_ECHO;
      ST_RPLAY: if (tx_ready && rp_q + 1'b1 >= len_q) st_d = ST_IDLE;
      ST_FLUSH: if (cmd_ready && rp_q + 1'b1 >= len_q) st_d = ST_PRMT;
      ST_ACK:   if (tx_ready && ack_q == 2'd2) st_d = ST_TERM;
      ST_TERM:  if (tx_ready && (echo_on || term_sel == TERM_CR || term_sel == TERM_LF ||
                    ack_q == 2'd3)) st_d = echo_on ? ST_PRMT : ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  always_comb begin
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    case (st_q)
      ST_PRMT:  begin tx_valid = 1'b1; tx_data = CH_PRMT; end
      ST_ECHO:  begin tx_valid = 1'b1; tx_data = echo_q; end
      ST_CARET: begin tx_valid = 1'b1; tx_data = CH_CARET; end
      ST_RPLAY: begin tx_valid = (len_q != '0); tx_data = line_q[rp_q[7:0]]; end
      ST_ACK:   begin tx_valid = 1'b1; tx_data = (ack_q == 2'd2) ? 8'h4C :
                                                 (ack_q == 2'd1) ? 8'h43 : 8'h44; end
      ST_TERM:  begin
        tx_valid = 1'b1;
        if (ack_q == 2'd3)
          tx_data = (term_sel == TERM_CRLF) ? CH_LF : CH_CR;
        else
          tx_data = (term_sel == TERM_LF || term_sel == TERM_LFCR) ? CH_LF : CH_CR;
      end
      default: begin
        if (flow_pend_q) begin
          tx_valid = 1'b1;
          tx_data  = xoff_q ? CH_DC3 : CH_DC1;
        end
      end
    endcase
  end

  // parser stream: buffered flush in echo mode, direct pass otherwise
  assign cmd_valid   = (st_q == ST_FLUSH) ? (len_q != '0) :
                       (rx_ok && !echo_on && !rx_error && !(drop_q && !pass_end) &&
                        !(soft_flow_on && flow_char && !in_blk));
  assign cmd_data    = (st_q == ST_FLUSH) ? line_q[rp_q[7:0]] : rx.data;
  assign cmd_restart = rx.valid && rx.brk;
  assign in_bblock   = in_blk;
  assign verbose     = verbose_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (store_chr && !line_full && idle_st)
      line_q[len_q[7:0]] <= rx.data;
  end

  // line length, escape and replay pointer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      len_q  <= '0;
      rp_q   <= '0;
      esc_q  <= 1'b0;
      echo_q <= 8'h00;
    end else begin
      if ((rx.valid && rx.brk) || (rx_error && echo_on) || do_kill || line_full) begin
        len_q <= '0;
        esc_q <= 1'b0;
      end else if (idle_st && do_erase && len_q != '0) begin
        len_q <= len_q - 1'b1;
      end else if (idle_st && store_chr) begin
        len_q <= len_q + 1'b1;
        esc_q <= 1'b0;
      end else if (idle_st && take_esc) begin
        esc_q <= 1'b1;
      end else if (st_q == ST_FLUSH && st_d == ST_PRMT) begin
        len_q <= '0;
      end
      if (idle_st && rx_ok)
        echo_q <= is_ctl(rx.data) ? (rx.data ^ CH_CTLB) : rx.data;
      if (idle_st)
        rp_q <= '0;
      else if ((st_q == ST_RPLAY && tx_ready) || (st_q == ST_FLUSH && cmd_ready))
        rp_q <= rp_q + 1'b1;
    end
  end

  // binary block count, drop-to-delimiter, clear-ack sequencing, flow control
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blk_q       <= 16'h0000;
      drop_q      <= 1'b0;
      ack_q       <= 2'd0;
      xoff_q      <= 1'b0;
      flow_pend_q <= 1'b0;
    end else begin
      if (rx.valid && rx.brk)
        blk_q <= 16'h0000;
      else if (bblock_start && !echo_on)
        blk_q <= bblock_len;
      else if (rx_ok && in_blk)
        blk_q <= blk_q - 16'h0001;
      if (rx_error && !echo_on)
        drop_q <= 1'b1;
      else if ((rx_ok && pass_end) || (rx.valid && rx.brk))
        drop_q <= 1'b0;
      // count parks at 2 so that the terminator state starts on its first byte
      if (st_q == ST_ACK && tx_ready && ack_q != 2'd2)
        ack_q <= ack_q + 2'd1;
      else if (st_q == ST_ACK)
        ack_q <= ack_q;
      else if (st_q == ST_TERM && tx_ready)
        ack_q <= (ack_q == 2'd2) ? 2'd3 : 2'd0;
      else if (idle_st)
        ack_q <= 2'd0;
      if (xoff_need || xon_need) begin
        xoff_q      <= xoff_need;
        flow_pend_q <= 1'b1;
      end else if (idle_st && tx_ready && flow_pend_q) begin
        flow_pend_q <= 1'b0;
      end
    end
  end

  // verbose setting and replies
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      verbose_q      <= VERBOSE_RST;
      cmd_err_seen_q <= 1'b0;
      pwr_sent_q     <= 1'b0;
      reply_ok       <= 1'b0;
      reply_event    <= 1'b0;
      reply_answer   <= 1'b0;
      reply_code     <= 10'd0;
      reply_text     <= 1'b0;
      evt            <= '0;
      display_err    <= 1'b0;
    end else begin
      if (verbose_set)
        verbose_q <= verbose_val;
      reply_ok     <= 1'b0;
      reply_event  <= 1'b0;
      reply_answer <= 1'b0;
      evt          <= '0;
      display_err  <= rx_error;
      reply_text   <= long_response_form;
      if (cmd_err && !reply_busy)
        cmd_err_seen_q <= 1'b1;
      if (cmd_done) begin
        cmd_err_seen_q <= 1'b0;
        if (cmd_err_seen_q || cmd_err) begin
          reply_event <= verbose_q;
        end else if (cmd_is_query) begin
          reply_answer <= 1'b1;
        end else begin
          reply_ok <= verbose_q;
        end
      end
      if (cmd_err && !cmd_err_seen_q)
        reply_code <= cmd_err_code;
      if (cmd_err)
        evt <= '{valid: 1'b1, code: cmd_err_code, send: 1'b0};
      if (powerup_done && !pwr_sent_q) begin
        pwr_sent_q <= 1'b1;
        evt <= '{valid: 1'b1, code: selftest_fail ? EV_PWR_FAIL : EV_PWR_OK,
                 send: verbose_q};
      end else if (rx_error) begin
        evt <= '{valid: 1'b1, code: rx_err_cd, send: 1'b1};
      end else if (line_full) begin
        evt <= '{valid: 1'b1, code: EV_LINE_OVF, send: 1'b1};
      end else if (bblock_start && echo_on) begin
        evt <= '{valid: 1'b1, code: EV_ECHO_BLK, send: 1'b0};
      end
    end
  end
endmodule

// ### scfe_pkg.sv
// package for the serial command front end: codes, characters, carrier structs
// assumes the uart and the command parser sit outside and speak byte streams
// Functional notes
// - echo on, incoming binary block is dropped and event 164 raised.
// - both ends use eight-bit characters.
// - echo on, every received character goes back to the sender; code does not echo unescaped editing characters, or dc1/dc3 with soft flow on.
// - echo on, a '>' prompt asks for each new command line.
// - echo on, whole line buffered until terminator; echo off, pass immediately.
// - control-r resends pending line; control-u discards it and restarts line.
// - backspace and delete remove the last buffered character.
// - backslash makes next editing character literal; double backslash stores one.
// - line past 256 bytes is discarded, buffer emptied, event 163 sent.
// - echo on, control codes echo as caret plus printable character.
// - bs, lf, cr, dc2, nak, del caret-echo only escaped; dc1/dc3 only without soft flow; code also caret-echoes escaped dc1/dc3 with soft flow on.
// - verbose on, each command gets one reply: ok, answer or event.
// - several errors in one command give one reply, rest queued.
// - verbose off, only valid queries reply; errors still queued.
// - verbose setting defaults to off.
// - after power-up with verbose on, send event 401 or 394; else queue.
// - break acknowledged by prompt (echo on) or clear string plus terminator.
// - break empties serial buffers and restarts processing, settings untouched.
// - receive errors report 653 parity, 654 framing, 655 overrun.
// - echo off, after receive error drop input to next semicolon or terminator.
// - echo on, after receive error discard buffered input and prompt again.
// - terminator selectable: cr, lf, cr-lf, lf-cr.
// - within a binary block cr and lf are data until the count is met.
package scfe_pkg;
  localparam int        LINE_MAX    = 256;
  localparam int        LINE_AW     = 9;
  localparam int        XOFF_LEVEL  = 240;
  localparam int        XON_LEVEL   = 128;
  localparam logic [9:0] EV_ECHO_BLK = 10'd164;
  localparam logic [9:0] EV_LINE_OVF = 10'd163;
  localparam logic [9:0] EV_PWR_OK   = 10'd401;
  localparam logic [9:0] EV_PWR_FAIL = 10'd394;
  localparam logic [9:0] EV_PARITY   = 10'd653;
  localparam logic [9:0] EV_FRAMING  = 10'd654;
  localparam logic [9:0] EV_OVERRUN  = 10'd655;
  localparam logic [7:0] CH_BS    = 8'h08;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_DC1   = 8'h11;
  localparam logic [7:0] CH_DC2   = 8'h12;
  localparam logic [7:0] CH_DC3   = 8'h13;
  localparam logic [7:0] CH_NAK   = 8'h15;
  localparam logic [7:0] CH_DEL   = 8'h7F;
  localparam logic [7:0] CH_BSL   = 8'h5C;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_PRMT  = 8'h3E;
  localparam logic [7:0] CH_CARET = 8'h5E;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CTLB  = 8'h40;
  localparam logic [1:0] TERM_CR   = 2'd0;
  localparam logic [1:0] TERM_LF   = 2'd1;
  localparam logic [1:0] TERM_CRLF = 2'd2;
  localparam logic [1:0] TERM_LFCR = 2'd3;
  localparam logic       VERBOSE_RST = 1'b0;

  // receive side byte from the uart, with its error flags
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
    logic       ovr_err;
    logic       brk;
  } scfe_rx_s;

  // event posted toward the event queue; send marks an unsolicited serial reply
  typedef struct packed {
    logic       valid;
    logic [9:0] code;
    logic       send;
  } scfe_evt_s;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_PRMT  = 8'b0000_0010,
    ST_ECHO  = 8'b0000_0100,
    ST_CARET = 8'b0000_1000,
    ST_RPLAY = 8'b0001_0000,
    ST_FLUSH = 8'b0010_0000,
    ST_ACK   = 8'b0100_0000,
    ST_TERM  = 8'b1000_0000
  } scfe_state_e;
endpackage

// ### scfe_chk.sv
// assertions on the serial command front end ports
// assumes one core_clk domain and async active-low nrst
`timescale 1ns/10ps
module scfe_chk (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire scfe_pkg::scfe_rx_s  rx,
  input wire logic                echo_on,
  input wire logic                bblock_start,
  input wire logic                powerup_done,
  input wire logic                selftest_fail,
  input wire logic                cmd_done,
  input wire logic                cmd_err,
  input wire logic [9:0]          cmd_err_code,
  input wire logic                cmd_is_query,
  input wire logic                tx_ready,
  input wire logic                cmd_restart,
  input wire logic                tx_valid,
  input wire logic [7:0]          tx_data,
  input wire logic                reply_ok,
  input wire logic                reply_event,
  input wire logic [9:0]          reply_code,
  input wire scfe_pkg::scfe_evt_s evt,
  input wire logic                display_err,
  input wire logic                verbose
);
  import scfe_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire rx_err = rx.valid && (rx.par_err || rx.frm_err || rx.ovr_err);
  // only bytes taken while the echo path is idle
  wire rx_plain = rx.valid && !rx_err && !rx.brk && !tx_valid && echo_on;
  sequence brk_quiet;
    rx.valid && rx.brk && !echo_on;
  endsequence
  sequence ack_lead;
    ##[1:4] (tx_valid && tx_data == 8'h44);
  endsequence
  blk_evt_a: assert property (echo_on && bblock_start |=> evt.valid && evt.code == EV_ECHO_BLK)
    else $error("block in echo mode without event");
  par_evt_a: assert property (rx_err && rx.par_err |=> evt.valid && evt.send && evt.code == EV_PARITY)
    else $error("parity error event missing");
  ovr_evt_a: assert property (rx_err && rx.ovr_err && !rx.par_err && !rx.frm_err
    |=> evt.valid && evt.code == EV_OVERRUN)
    else $error("overrun event missing");
  err_disp_a: assert property (rx_err |=> display_err)
    else $error("display error flag missing");
  echo_char_a: assert property (rx_plain && rx.data inside {[8'h41:8'h5a]}
    |=> tx_valid && tx_data == $past(rx.data))
    else $error("character not echoed");
  caret_echo_a: assert property (rx_plain && rx.data inside {[8'h01:8'h07]}
    |=> tx_valid && tx_data == CH_CARET)
    else $error("control code echo lacks caret");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("echo byte dropped before accept");
  brk_restart_a: assert property (rx.valid && rx.brk |-> cmd_restart)
    else $error("break did not restart parser");
  brk_ack_a: assert property (brk_quiet |-> ack_lead)
    else $error("break acknowledge not started");
  verb_reply_a: assert property (verbose && cmd_done && cmd_err
    |=> reply_event && reply_code == $past(cmd_err_code))
    else $error("verbose error reply missing");
  quiet_a: assert property (!verbose && cmd_done && !cmd_is_query |=> !reply_ok && !reply_event)
    else $error("reply sent with verbose off");
  verb_rst_a: assert property ($rose(nrst) |-> !verbose)
    else $error("verbose not off after reset");
  pwr_ok_a: assert property ($rose(powerup_done) && verbose && !selftest_fail
    |=> evt.valid && evt.send && evt.code == EV_PWR_OK)
    else $error("power-up event missing");
endmodule
bind scfe_front_end scfe_chk chk_u (.core_clk(core_clk), .nrst(nrst), .rx(rx), .echo_on(echo_on),
  .bblock_start(bblock_start), .powerup_done(powerup_done), .selftest_fail(selftest_fail),
  .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_err_code(cmd_err_code),
  .cmd_is_query(cmd_is_query), .tx_ready(tx_ready), .cmd_restart(cmd_restart),
  .tx_valid(tx_valid), .tx_data(tx_data), .reply_ok(reply_ok), .reply_event(reply_event),
  .reply_code(reply_code), .evt(evt), .display_err(display_err), .verbose(verbose));

// ### scfe_term_model.sv
// terminal model: sends bytes and breaks, accepts echoed bytes
// assumes the bench paces it; slow makes it stall each byte two cycles
`timescale 1ns/10ps
module scfe_term_model (
  input  wire logic          core_clk,
  input  wire logic          tx_valid,
  input  wire logic [7:0]    tx_data,
  input  wire logic          slow,
  output scfe_pkg::scfe_rx_s rx,
  output logic               tx_ready
);
  import scfe_pkg::*;
  logic [7:0] got_q[$];
  int         stall_n = 0;
  initial rx = '0;
  initial tx_ready = 1'b0;
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
    #1;
    stall_n = (tx_valid && !tx_ready) ? stall_n + 1 : 0;
    tx_ready = !slow || stall_n >= 2;
  end
  // flags are {parity, framing, overrun, break}
  task automatic send(input logic [7:0] b, input logic [3:0] f);
    @(posedge core_clk);
    #1;
    rx = '{1'b1, b, f[3], f[2], f[1], f[0]};
    @(posedge core_clk);
    #1;
    rx = '0;
    // the design drops bytes while echoing, so wait for the echo to drain
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 60 && tx_valid; i++) @(posedge core_clk);
    #1;
  endtask
endmodule

// ### scfe_tb.sv
// self-checking bench for the serial command front end
// assumes scfe_term_model as terminal and scfe_chk bound to the design
`timescale 1ns/10ps
module tb;
  import scfe_pkg::*;
  logic       core_clk, nrst, echo_on, verbose_set, verbose_val, soft_flow_on, slow;
  logic       bblock_start, powerup_done, cmd_done, cmd_err, cmd_is_query, tx_ready;
  logic       tx_valid, cmd_valid, cmd_restart, reply_ok, reply_event, display_err, verbose;
  logic       long_response_form, selftest_fail, reply_text, reply_answer, in_bblock;
  logic [1:0] term_sel;
  logic [9:0] cmd_err_code, reply_code;
  logic [7:0] tx_data, cmd_data, cmd_q[$];
  logic [9:0] ev_q[$], rep_q[$];
  scfe_rx_s   rx;
  scfe_evt_s  evt;
  int         n_errors = 0;
  int         tests_run = 0;
  scfe_front_end dut_u (.core_clk(core_clk), .nrst(nrst), .rx(rx), .echo_on(echo_on),
    .verbose_set(verbose_set), .verbose_val(verbose_val),
    .long_response_form(long_response_form),
    .soft_flow_on(soft_flow_on), .term_sel(term_sel), .bblock_start(bblock_start),
    .bblock_len(16'h0002), .powerup_done(powerup_done), .selftest_fail(selftest_fail),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_err_code(cmd_err_code),
    .cmd_is_query(cmd_is_query), .tx_ready(tx_ready), .reply_busy(1'b0), .cmd_ready(1'b1),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_restart(cmd_restart),
    .tx_valid(tx_valid), .tx_data(tx_data), .reply_ok(reply_ok), .reply_event(reply_event),
    .reply_code(reply_code), .reply_text(reply_text), .reply_answer(reply_answer), .evt(evt),
    .display_err(display_err), .verbose(verbose), .in_bblock(in_bblock));
  scfe_term_model term_u (.core_clk(core_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .slow(slow), .rx(rx), .tx_ready(tx_ready));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (evt.valid === 1'b1) ev_q.push_back(evt.code);
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd_data);
    if (reply_event === 1'b1) rep_q.push_back(reply_code);
    if (reply_ok === 1'b1) rep_q.push_back(10'h3ff);
    if (reply_answer === 1'b1) rep_q.push_back(10'h3fe);
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic clr();
    ev_q.delete();
    rep_q.delete();
    cmd_q.delete();
    term_u.got_q.delete();
  endtask
  task automatic wait_prompt();
    for (int i = 0; i < 600 && (term_u.got_q.size() == 0 || term_u.got_q[$] !== CH_PRMT); i++)
      tick(1);
  endtask
  task automatic t_echo_line();
    echo_on = 1'b1;
    slow = 1'b1;
    tick(4);
    clr();
    term_u.send(8'h41, 4'h0);
    term_u.send(8'h42, 4'h0);
    chk("echo first", 8'h41, term_u.got_q[0]);
    chk("echo second", 8'h42, term_u.got_q[1]);
    chk("early parse", 0, cmd_q.size());
    term_u.send(CH_CR, 4'h0);
    wait_prompt();
    chk("line first", 8'h41, cmd_q[0]);
    chk("line second", 8'h42, cmd_q[1]);
    chk("prompt", CH_PRMT, term_u.got_q[$]);
    clr();
    term_u.send(8'h01, 4'h0);
    chk("caret", CH_CARET, term_u.got_q[0]);
    chk("caret char", 8'h41, term_u.got_q[1]);
    soft_flow_on = 1'b1;
    clr();
    term_u.send(CH_DC1, 4'h0);
    chk("flow quiet", 0, term_u.got_q.size());
    soft_flow_on = 1'b0;
    term_u.send(CH_NAK, 4'h0);
    term_u.send(8'h51, 4'h0);
    term_u.send(CH_DEL, 4'h0);
    term_u.send(8'h52, 4'h0);
    clr();
    term_u.send(CH_CR, 4'h0);
    wait_prompt();
    chk("edited line", 8'h52, cmd_q[0]);
    // block sent with soft flow off, as the host must
    clr();
    bblock_start = 1'b1;
    tick(1);
    bblock_start = 1'b0;
    tick(3);
    chk("block event", EV_ECHO_BLK, ev_q[0]);
    $display("test echo done");
  endtask
  task automatic t_echo_off();
    logic [7:0] ack[5] = '{8'h44, 8'h43, 8'h4c, CH_CR, CH_LF};
    echo_on = 1'b0;
    slow = 1'b0;
    tick(8);
    clr();
    term_u.send(8'h5a, 4'h0);
    chk("pass byte", 8'h5a, cmd_q[0]);
    chk("no echo", 0, term_u.got_q.size());
    bblock_start = 1'b1;
    tick(1);
    bblock_start = 1'b0;
    term_u.send(CH_CR, 4'h0);
    chk("block open", 1, in_bblock);
    term_u.send(CH_LF, 4'h0);
    chk("block closed", 0, in_bblock);
    for (int i = 0; i < 3; i++) begin
      clr();
      term_u.send(8'h41, 4'h8 >> i);
      chk("error event", EV_PARITY + i, ev_q[0]);
    end
    term_u.send(8'h58, 4'h0);
    term_u.send(CH_SEMI, 4'h0);
    term_u.send(8'h59, 4'h0);
    chk("resume", 8'h59, cmd_q[$]);
    chk("dropped", 0, cmd_q[0] == 8'h58);
    term_sel = TERM_CRLF;
    slow = 1'b1;
    clr();
    term_u.send(8'h00, 4'h1);
    for (int i = 0; i < 400 && term_u.got_q.size() < 5; i++) tick(1);
    for (int i = 0; i < 5; i++) chk("clear ack", ack[i], term_u.got_q[i]);
    $display("test echo off done");
  endtask
  task automatic t_verbose();
    chk("verbose reset", 0, verbose);
    verbose_set = 1'b1;
    verbose_val = 1'b1;
    tick(1);
    verbose_set = 1'b0;
    tick(1);
    chk("verbose on", 1, verbose);
    long_response_form = 1'b1;
    tick(1);
    chk("long form", 1, reply_text);
    clr();
    cmd_done = 1'b1;
    cmd_err = 1'b1;
    tick(1);
    cmd_err = 1'b0;
    tick(1);
    cmd_done = 1'b0;
    tick(2);
    chk("event reply", 10'h09c, rep_q[0]);
    chk("ok reply", 10'h3ff, rep_q[1]);
    cmd_is_query = 1'b1;
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    cmd_is_query = 1'b0;
    tick(2);
    chk("answer", 10'h3fe, rep_q[2]);
    powerup_done = 1'b1;
    tick(3);
    chk("power event", EV_PWR_OK, ev_q[$]);
    verbose_set = 1'b1;
    verbose_val = 1'b0;
    tick(1);
    verbose_set = 1'b0;
    cmd_done = 1'b1;
    cmd_err = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    cmd_err = 1'b0;
    tick(2);
    chk("quiet", 3, rep_q.size());
    // second reset in mid-run: verbose back off, failed self-test reported
    selftest_fail = 1'b1;
    nrst = 1'b0;
    tick(2);
    clr();
    nrst = 1'b1;
    tick(3);
    chk("verbose rearm", 0, verbose);
    chk("fail event", EV_PWR_FAIL, ev_q[0]);
    $display("test verbose done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {nrst, echo_on, verbose_set, verbose_val, soft_flow_on, slow} = '0;
    {bblock_start, powerup_done, cmd_done, cmd_err, cmd_is_query, term_sel} = '0;
    {long_response_form, selftest_fail} = '0;
    cmd_err_code = 10'h09c;
    repeat (8) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    tick(2);
    t_verbose();
    t_echo_line();
    t_echo_off();
    finish_test();
  end
  initial begin
    #300000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
